// *** hdl/addr_stage.sv ***
// Memory bus address output stage: line and sub-line latches,
// line address parity pin and snoop address parity error output.
// Assumes the bus controller drives all pins to valid levels and the
// core supplies address and cycle strobe on sys_clk.
// Operation
// - Parity pin driven while line output enable low, input otherwise.
// - Synchronous mode samples parity at first clock with strobe active.
// - Clocked mode samples parity at first snoop clock rise with strobe.
// - Strobed mode samples parity at strobe falling edge.
// - Parity sampled only with strobe activation, ignored otherwise.
// - Parity, address and strobe out valid in the same clock.
// - Line latch enable also latches the parity bit.
// - Line output enable also enables the parity driver.
// - Error asserted when sampled parity mismatches snooped line address.
// - Error high from reset until one clock after init finishes.
// - No parity check on strobes while init or self-test runs.
// - Synchronous mode error valid two clocks after strobe, held after.
// - Other modes error valid one clock after snoop cycle, held after.
// - Error inactive during reset and at least five clocks after.
// - Sub-line bits use their own latch enable, rest use line enable.
// - Sub-line latch transparent while its enable is high.
// - Sub-line latch holds once its enable falls.
// - Sub-line latch works regardless of output enables.
// - Sub-line output enable acts apart from line output enable.
// - Line latch holds while its enable is low, passes when high.
// - Snoop with line output enable active is not sampled; in clocked and strobed modes its cycle marker still re-drives the last result.
// - Parity is even over set, tag and config fields only.
`timescale 1ns/1ps
module addr_stage
  import addr_stage_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Core side
  input wire line_addr_t core_line_addr,
  input wire logic [SUB_W-1:0] core_subline_addr,
  input wire logic core_cycle_n,
  input wire snoop_mode_t snoop_mode,
  input wire logic init_selftest_busy_n,
  // Latch and enable pins
  input wire logic line_addr_latch_en,
  input wire logic subline_addr_latch_en,
  input wire logic line_addr_out_en_n,
  input wire logic subline_addr_out_en_n,
  // Snoop pins
  input wire logic snoop_strobe_n,
  input wire logic snoop_clock,
  input wire logic snoop_cycle_n,
  // Address bus pins
  input wire line_addr_t line_addr_i,
  output line_addr_t line_addr_o,
  output logic line_addr_oe,
  output logic [SUB_W-1:0] subline_addr_o,
  output logic subline_addr_oe,
  input wire logic line_addr_parity_i,
  output logic line_addr_parity_o,
  output logic line_addr_parity_oe,
  output logic mem_cycle_addr_strobe_n,
  output logic addr_parity_error_n
);

  pin_in_t pin_raw;
  pin_in_t s1_q, s2_q, s3_q, f_q, f_d;

  // Idle pin levels: enables parked off so reset never drives the bus
  localparam pin_in_t PIN_IDLE = '{line_addr_latch_en: 1'b0,
    subline_addr_latch_en: 1'b0, line_addr_out_en_n: 1'b1,
    subline_addr_out_en_n: 1'b1, snoop_strobe_n: 1'b1,
    snoop_clock: 1'b0, snoop_cycle_n: 1'b1, parity: 1'b0,
    addr: '0};
  assign pin_raw = '{line_addr_latch_en, subline_addr_latch_en,
                     line_addr_out_en_n, subline_addr_out_en_n,
                     snoop_strobe_n, snoop_clock, snoop_cycle_n,
                     line_addr_parity_i, line_addr_i};

  // Filter: a bit moves only when stages two and three agree
  always_comb begin
    f_d = ((s2_q ~^ s3_q) & s3_q) | ((s2_q ^ s3_q) & f_q);
  end

  // Three-stage synchroniser, parked at idle pin levels
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= PIN_IDLE;
      s2_q <= PIN_IDLE;
      s3_q <= PIN_IDLE;
      f_q <= PIN_IDLE;
    end else begin
      s1_q <= pin_raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      f_q <= f_d;
    end
  end

  // Output latch stage
  line_addr_t line_q, line_d;
  logic [SUB_W-1:0] sub_q, sub_d;
  logic par_q, par_d, cyc_n_q;
  logic line_oe_q, sub_oe_q;

  // Latches modelled as clocked holds: pins are asynchronous, so
  // transparency costs the synchroniser delay plus one clock.
  always_comb begin
    line_d = line_q;
    par_d = par_q;
    sub_d = sub_q;
    if (f_q.line_addr_latch_en) begin
      line_d = core_line_addr;
      par_d = even_parity(core_line_addr);
    end
    if (f_q.subline_addr_latch_en) begin
      sub_d = core_subline_addr;
    end
  end

  // Address, parity and cycle strobe registered on one edge
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_q <= '0;
      sub_q <= '0;
      par_q <= 1'b0;
      cyc_n_q <= 1'b1;
      line_oe_q <= 1'b0;
      sub_oe_q <= 1'b0;
    end else begin
      line_q <= line_d;
      sub_q <= sub_d;
      par_q <= par_d;
      cyc_n_q <= core_cycle_n;
      line_oe_q <= ~f_q.line_addr_out_en_n;
      sub_oe_q <= ~f_q.subline_addr_out_en_n;
    end
  end

  assign line_addr_o = line_q;
  assign subline_addr_o = sub_q;
  assign line_addr_parity_o = par_q;
  assign line_addr_oe = line_oe_q;
  assign line_addr_parity_oe = line_oe_q;
  assign subline_addr_oe = sub_oe_q;
  assign mem_cycle_addr_strobe_n = cyc_n_q;

  // Snoop sampling and error reporting
  logic stb_fall, sclk_rise, cyc_fall, take, taken_q, taken_d;
  logic bad, ready;
  logic chk_v_q, chk_v_d, mis_q, mis_d, res_q, res_d;
  logic init_done_q, init_done_d, err_n_q, err_n_d;
  logic [2:0] rst_cnt_q, rst_cnt_d;

  // Edges seen on the filtered pins
  always_comb begin
    stb_fall = f_q.snoop_strobe_n & ~f_d.snoop_strobe_n;
    sclk_rise = ~f_q.snoop_clock & f_d.snoop_clock;
    cyc_fall = f_q.snoop_cycle_n & ~f_d.snoop_cycle_n;
  end

  assign ready = init_done_q && rst_cnt_q == RST_CNT_ZERO;
  assign bad = f_d.parity != even_parity(f_d.addr);

  // One sample per strobe, qualified by output enable and init state
  always_comb begin
    taken_d = taken_q;
    if (f_d.snoop_strobe_n) begin
      taken_d = 1'b0;
    end
    unique case (snoop_mode)
      SNOOP_CLOCKED: take = sclk_rise && !f_d.snoop_strobe_n && !taken_q;
      SNOOP_STROBED: take = stb_fall;
      default: take = stb_fall;
    endcase
    take = take && f_d.line_addr_out_en_n
      && init_selftest_busy_n;
    if (take) begin
      taken_d = 1'b1;
    end
    chk_v_d = take;
    mis_d = take ? bad : mis_q;
    res_d = res_q;
    if (take) begin
      res_d = bad;
    end
    init_done_d = init_done_q;
    if (!init_selftest_busy_n) begin
      init_done_d = 1'b0;
    end else if (!init_done_q) begin
      init_done_d = 1'b1;
    end
    rst_cnt_d = rst_cnt_q;
    if (rst_cnt_q != RST_CNT_ZERO) begin
      rst_cnt_d = rst_cnt_q - RST_CNT_ONE;
    end
    err_n_d = err_n_q;
    if (snoop_mode == SNOOP_SYNC) begin
      if (chk_v_q) begin
        err_n_d = ~mis_q;
      end
    end else if (cyc_fall) begin
      err_n_d = ~res_q;
    end
    // Busy also forces quiet, so an old result never shows in init
    if (!ready || !init_selftest_busy_n) begin
      err_n_d = 1'b1;
    end
  end

  // Error pin from a flop keeps it glitch free
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      taken_q <= 1'b0;
      chk_v_q <= 1'b0;
      mis_q <= 1'b0;
      res_q <= 1'b0;
      init_done_q <= 1'b0;
      rst_cnt_q <= RST_QUIET_CLKS;
      err_n_q <= 1'b1;
    end else begin
      taken_q <= taken_d;
      chk_v_q <= chk_v_d;
      mis_q <= mis_d;
      res_q <= res_d;
      init_done_q <= init_done_d;
      rst_cnt_q <= rst_cnt_d;
      err_n_q <= err_n_d;
    end
  end

  assign addr_parity_error_n = err_n_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  sequence s_sync_bad;
    snoop_mode == SNOOP_SYNC && take && bad && ready;
  endsequence
  sequence s_ready_two;
    ready [*2];
  endsequence

  chk_sync_err_time: assert property (s_sync_bad ##1 s_ready_two |->
    !addr_parity_error_n) else $error("sync error late");
  chk_quiet_reset: assert property (rst_cnt_q != RST_CNT_ZERO |->
    addr_parity_error_n) else $error("error during quiet");
  chk_busy_quiet: assert property (!init_selftest_busy_n |=>
    addr_parity_error_n) else $error("error during init");
  chk_busy_no_take: assert property (!init_selftest_busy_n |-> !take)
    else $error("check during init");
  chk_oe_ignore: assert property (stb_fall && !f_d.line_addr_out_en_n
    |=> !chk_v_q) else $error("snoop not ignored");
  chk_line_hold: assert property (!f_q.line_addr_latch_en |=>
    $stable(line_addr_o) && $stable(line_addr_parity_o))
    else $error("line latch moved");
  chk_sub_flow: assert property (f_q.subline_addr_latch_en |=>
    subline_addr_o == $past(core_subline_addr))
    else $error("sub latch not open");
  chk_sub_hold: assert property (!f_q.subline_addr_latch_en |=>
    $stable(subline_addr_o)) else $error("sub latch moved");
  chk_pin_oe: assert property (!line_addr_out_en_n [*5] |=>
    line_addr_parity_oe) else $error("parity not driven");
  chk_cycle_par: assert property (!mem_cycle_addr_strobe_n &&
    $past(f_q.line_addr_latch_en) |-> line_addr_parity_o ==
    even_parity(line_addr_o)) else $error("parity mismatch");
  chk_async_err: assert property (snoop_mode != SNOOP_SYNC && cyc_fall
    && ready ##1 ready |-> addr_parity_error_n == !$past(res_q))
    else $error("async error wrong");

  // A clean synchronous snoop must leave the error pin inactive
  sequence s_sync_good;
    snoop_mode == SNOOP_SYNC && take && !bad && ready;
  endsequence

  chk_sync_good: assert property (s_sync_good ##1 s_ready_two |->
    addr_parity_error_n) else $error("false sync error");
  chk_take_strobe: assert property (take |-> !f_d.snoop_strobe_n)
    else $error("sample without strobe");
  chk_one_take: assert property (snoop_mode == SNOOP_CLOCKED &&
    taken_q |-> !take) else $error("second clocked take");
  chk_reset_count: assert property (rst_cnt_q != RST_CNT_ZERO |=>
    rst_cnt_q == $past(rst_cnt_q) - RST_CNT_ONE)
    else $error("quiet count stuck");

  // Output stage follows the filtered enables, and the strobe follows core_cycle_n, one clock later
  chk_line_flow: assert property (f_q.line_addr_latch_en |=>
    line_addr_o == $past(core_line_addr))
    else $error("line latch not open");
  chk_sub_oe: assert property (subline_addr_oe ==
    !$past(f_q.subline_addr_out_en_n))
    else $error("sub oe wrong");
  chk_par_oe_tie: assert property (line_addr_parity_oe == line_addr_oe)
    else $error("parity oe split");
  chk_cycle_strobe: assert property (mem_cycle_addr_strobe_n ==
    $past(core_cycle_n))
    else $error("cycle strobe late");

endmodule : addr_stage

// *** pkg/addr_stage_pkg.sv ***
// Constants and types for the memory bus address output stage.
// Assumes one system clock; all pins arrive asynchronous to it.
package addr_stage_pkg;
  localparam int SET_W = 11;
  localparam int TAG_W = 12;
  localparam int CFG_W = 7;
  localparam int SUB_W = 2;
  // Least clocks of quiet error pin after reset release
  localparam logic [2:0] RST_QUIET_CLKS = 3'h5;
  localparam logic [2:0] RST_CNT_ZERO = 3'h0;
  localparam logic [2:0] RST_CNT_ONE = 3'h1;
  // Clocks from strobe detect to error pin in synchronous snoop mode
  localparam int SYNC_ERR_CLKS = 2;
  // Clocks from snoop cycle detect to error pin in other snoop modes
  localparam int ASYNC_ERR_CLKS = 1;

  typedef enum logic [1:0] {
    SNOOP_SYNC,
    SNOOP_CLOCKED,
    SNOOP_STROBED
  } snoop_mode_t;

  // Line address: everything except the burst sub-line bits
  typedef struct packed {
    logic [CFG_W-1:0] config_addr_field;
    logic [TAG_W-1:0] tag_addr_field;
    logic [SET_W-1:0] set_addr_field;
  } line_addr_t;

  // Pins that pass the input synchroniser
  typedef struct packed {
    logic line_addr_latch_en;
    logic subline_addr_latch_en;
    logic line_addr_out_en_n;
    logic subline_addr_out_en_n;
    logic snoop_strobe_n;
    logic snoop_clock;
    logic snoop_cycle_n;
    logic parity;
    line_addr_t addr;
  } pin_in_t;

  // Even parity: bit that makes the count of ones even
  function automatic logic even_parity(input line_addr_t a);
    return ^a;
  endfunction : even_parity
endpackage : addr_stage_pkg

// *** tb/snoop_agent.sv ***
// Snoop agent model: drives snoop address, parity and strobes.
// Assumes the stage filters its pins on sys_clk before use.
`timescale 1ns/1ps
module snoop_agent
  import addr_stage_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Snoop pins
  output line_addr_t line_addr_i,
  output logic line_addr_parity_i,
  output logic snoop_strobe_n,
  output logic snoop_clock,
  output logic snoop_cycle_n
);
  // Pins idle until a frame starts; snoop clock stands still
  initial begin
    line_addr_i = '0;
    line_addr_parity_i = 1'b1;
    snoop_strobe_n = 1'b1;
    snoop_clock = 1'b0;
    snoop_cycle_n = 1'b1;
  end

  // Each step holds 5 clocks so the input filter sees it
  task automatic snoop(input line_addr_t a, input logic bad,
                       input snoop_mode_t m);
    @(negedge sys_clk);
    line_addr_i = a;
    line_addr_parity_i = ^a ^ bad;
    snoop_strobe_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    snoop_clock = 1'b1;
    repeat (5) @(negedge sys_clk);
    snoop_cycle_n = (m == SNOOP_SYNC); // Marker only in async modes
    repeat (5) @(negedge sys_clk);
    snoop_strobe_n = 1'b1;
    snoop_clock = 1'b0;
    snoop_cycle_n = 1'b1;
    // Released pins show garbage, never the last value
    line_addr_i = ~a;
    line_addr_parity_i = ~line_addr_parity_i;
  endtask : snoop
endmodule : snoop_agent

// *** tb/test_addr_stage.sv ***
// Self-checking bench for the memory bus address output stage.
// Assumes the snoop agent model owns the snoop pins.
`timescale 1ns/1ps
module test_addr_stage;
  import addr_stage_pkg::*;
  localparam line_addr_t ADDR_A = 30'h1A5C3E17;
  localparam line_addr_t ADDR_B = 30'h0E3A71C6;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  line_addr_t core_line_addr = '0;
  logic [SUB_W-1:0] core_subline_addr = '0;
  logic core_cycle_n = 1'b1;
  snoop_mode_t snoop_mode = SNOOP_SYNC;
  logic init_selftest_busy_n = 1'b0;
  logic line_addr_latch_en = 1'b1;
  logic subline_addr_latch_en = 1'b1;
  logic line_addr_out_en_n = 1'b1;
  logic subline_addr_out_en_n = 1'b1;
  line_addr_t line_addr_i, line_addr_o;
  logic [SUB_W-1:0] subline_addr_o;
  logic snoop_strobe_n, snoop_clock, snoop_cycle_n, line_addr_oe;
  logic subline_addr_oe, line_addr_parity_i, line_addr_parity_o;
  logic line_addr_parity_oe, mem_cycle_addr_strobe_n, addr_parity_error_n;
  int errors = 0;
  int samples_checked = 0;

  always #50 sys_clk = ~sys_clk;

  addr_stage u_dut (.sys_clk, .sys_rst, .core_line_addr, .core_subline_addr,
    .core_cycle_n, .snoop_mode, .init_selftest_busy_n, .line_addr_latch_en,
    .subline_addr_latch_en, .line_addr_out_en_n, .subline_addr_out_en_n,
    .snoop_strobe_n, .snoop_clock, .snoop_cycle_n, .line_addr_i,
    .line_addr_o, .line_addr_oe, .subline_addr_o, .subline_addr_oe,
    .line_addr_parity_i, .line_addr_parity_o, .line_addr_parity_oe,
    .mem_cycle_addr_strobe_n, .addr_parity_error_n);

  snoop_agent u_agent (.sys_clk, .line_addr_i, .line_addr_parity_i,
    .snoop_strobe_n, .snoop_clock, .snoop_cycle_n);

  // Four-state compare, zero-extended so one task serves all widths
  task automatic check(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wait_clks(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wait_clks

  task automatic test_reset();
    wait_clks(3);
    check("error in reset", 1'b1, addr_parity_error_n);
    sys_rst = 1'b0;
    for (int i = 0; i < 5; i++) begin
      wait_clks(1);
      check("error after reset", 1'b1, addr_parity_error_n);
    end
    u_agent.snoop(ADDR_A, 1'b1, SNOOP_SYNC);
    wait_clks(8);
    check("error while busy", 1'b1, addr_parity_error_n);
    init_selftest_busy_n = 1'b1;
    wait_clks(8);
    check("error after init", 1'b1, addr_parity_error_n);
    $display("test reset done");
  endtask : test_reset

  // Address, parity and enables must be valid with the cycle strobe
  task automatic test_cycle();
    core_line_addr = ADDR_A;
    core_subline_addr = 2'h3;
    line_addr_out_en_n = 1'b0;
    subline_addr_out_en_n = 1'b0;
    wait_clks(8);
    core_cycle_n = 1'b0;
    @(posedge sys_clk);
    #1;
    check("cycle strobe", 1'b0, mem_cycle_addr_strobe_n);
    check("line addr", ADDR_A, line_addr_o);
    check("parity out", ^ADDR_A, line_addr_parity_o);
    check("parity oe", 1'b1, line_addr_parity_oe);
    check("line oe", 1'b1, line_addr_oe);
    check("subline", 2'h3, subline_addr_o);
    check("subline oe", 1'b1, subline_addr_oe);
    wait_clks(1);
    core_cycle_n = 1'b1;
    $display("test cycle done");
  endtask : test_cycle

  task automatic test_latch();
    line_addr_latch_en = 1'b0;
    subline_addr_latch_en = 1'b0;
    wait_clks(8);
    core_line_addr = ADDR_B;
    core_subline_addr = 2'h1;
    subline_addr_out_en_n = 1'b1;
    wait_clks(8);
    check("held line", ADDR_A, line_addr_o);
    check("held parity", ^ADDR_A, line_addr_parity_o);
    check("held subline", 2'h3, subline_addr_o);
    check("subline off", 1'b0, subline_addr_oe);
    check("line still on", 1'b1, line_addr_oe);
    line_addr_latch_en = 1'b1;
    subline_addr_latch_en = 1'b1;
    line_addr_out_en_n = 1'b1;
    wait_clks(8);
    check("open line", ADDR_B, line_addr_o);
    check("open parity", ^ADDR_B, line_addr_parity_o);
    check("open subline", 2'h1, subline_addr_o);
    check("line off", 1'b0, line_addr_oe);
    check("parity off", 1'b0, line_addr_parity_oe);
    $display("test latch done");
  endtask : test_latch

  // Good and bad parity in every mode, then a snoop that must be ignored
  task automatic test_snoop();
    for (int k = 0; k < 6; k++) begin
      snoop_mode = snoop_mode_t'(k / 2);
      u_agent.snoop(ADDR_B ^ 30'(k), k % 2, snoop_mode);
      wait_clks(8);
      check("error flag", !(k % 2), addr_parity_error_n);
    end
    line_addr_out_en_n = 1'b0;
    wait_clks(8);
    u_agent.snoop(ADDR_A, 1'b0, snoop_mode);
    wait_clks(8);
    check("ignored snoop", 1'b0, addr_parity_error_n);
    $display("test snoop done");
  endtask : test_snoop

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // Tests need well under 400 clocks; the margin covers filter delay
  initial begin
    repeat (3000) @(posedge sys_clk);
    errors++;
    $display("[ERR] watchdog expired");
    wrap_up();
  end

  initial begin
    test_reset();
    test_cycle();
    test_latch();
    test_snoop();
    wrap_up();
  end
endmodule : test_addr_stage
